// [bbf_pkg.sv]
// Constants shared by the billboard failover control design.
package bbf_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [15:0] OFS_TMR1_LO   = 16'h413c;
    localparam logic [15:0] OFS_TMR1_HI   = 16'h413d;
    localparam logic [15:0] OFS_TMR2_LO   = 16'h413e;
    localparam logic [15:0] OFS_TMR2_HI   = 16'h413f;
    localparam logic [15:0] OFS_CTRL      = 16'h4140;
    localparam logic [15:0] OFS_STATUS    = 16'h4141;

    // ------------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------------
    localparam int          CTRL_EN_BIT   = 0;
    localparam int          CTRL_SEL_LSB  = 1;
    localparam int          CTRL_SEL_MSB  = 5;
    localparam logic [7:0]  CTRL_RST      = 8'h14;
    localparam logic [7:0]  CTRL_MASK     = 8'h3f;
    localparam logic [4:0]  SEL_DEFAULT   = 5'h0a;
    localparam logic [4:0]  SEL_RESERVED  = 5'h09;
    localparam int          NUM_PINS      = 17;
    localparam logic [7:0]  TMR_LO_RST    = 8'hd0;
    localparam logic [7:0]  TMR_HI_RST    = 8'h07;
    localparam logic [1:0]  CFG_UNSPEC    = 2'h0;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int          CLK_HZ        = 50000000;
    localparam int          TICK_MS       = 10;
    localparam int          TICK_CYC      = CLK_HZ / 1000 * TICK_MS;
    localparam int          DETACH_US     = 100;
    localparam int          DETACH_CYC    = CLK_HZ / 1000000 * DETACH_US;

    // ------------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_NORMAL  = 5'b00001,
        ST_DET_BB  = 5'b00010,
        ST_BILL    = 5'b00100,
        ST_DET_STD = 5'b01000,
        ST_HOLD    = 5'b10000
    } bbf_state_e;

endpackage

// [bbf_sync.sv]
// Two-flop synchroniser for the general-purpose pin bank.
`timescale 1ns/1ns
module bbf_sync #(
    parameter int W = 17
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    // Pins idle high, so both stages reset to the no-failure level.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '1;
            q      <= '1;
        end else if (ce) begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule

// [bbf_timer.sv]
// Detach timer counting 10 ms ticks up to a 16-bit limit.
`timescale 1ns/1ns
module bbf_timer (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic        start,
    input  wire logic        stop,
    input  wire logic        tick,
    input  wire logic [15:0] limit,
    output logic             expired,
    output logic             running
);
    logic [15:0] cnt_r;

    // A limit of zero expires on the first tick rather than never.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r   <= 16'h0000;
            running <= 1'b0;
            expired <= 1'b0;
        end else if (ce) begin
            expired <= 1'b0;
            if (stop) begin
                running <= 1'b0;
                cnt_r   <= 16'h0000;
            end else if (start && !running) begin
                running <= 1'b1;
                cnt_r   <= 16'h0000;
            end else if (running && tick) begin
                if (cnt_r + 16'h0001 >= limit) begin
                    running <= 1'b0;
                    expired <= 1'b1;
                end
                cnt_r <= cnt_r + 16'h0001;
            end
        end
    end
endmodule

// [bbf_ctrl.sv]
// Billboard failover sequencer with detach timers and register port.
`timescale 1ns/1ns
module bbf_ctrl (
    input  wire logic        MCLK,
    input  wire logic        ARST_N,
    input  wire logic        CE,
    input  wire logic [16:0] GPIO_IN,
    input  wire logic        ADDR_SET,
    input  wire logic        ALT_STR_REQ,
    input  wire logic [15:0] REG_ADDR,
    input  wire logic [7:0]  REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic      [7:0]  REG_RDATA,
    output logic             FUNC_CONNECT,
    output logic             BILLBOARD_MODE,
    output logic             MSG_FROM_OTP,
    output logic             ALT_STR_ACK,
    output logic      [1:0]  CONFIGURED_STATUS
);

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic       rst_meta_r;
    logic       rst_n_r;

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_meta_r <= 1'b0;
            rst_n_r    <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r    <= rst_meta_r;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0] tmr1_lo_r;
    logic [7:0] tmr1_hi_r;
    logic [7:0] tmr2_lo_r;
    logic [7:0] tmr2_hi_r;
    logic [7:0] ctrl_r;

    always_ff @(posedge MCLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            tmr1_lo_r <= bbf_pkg::TMR_LO_RST;
            tmr1_hi_r <= bbf_pkg::TMR_HI_RST;
            tmr2_lo_r <= bbf_pkg::TMR_LO_RST;
            tmr2_hi_r <= bbf_pkg::TMR_HI_RST;
            ctrl_r    <= bbf_pkg::CTRL_RST;
        end else if (CE && REG_WR) begin
            unique case (REG_ADDR)
                bbf_pkg::OFS_TMR1_LO: tmr1_lo_r <= REG_WDATA;
                bbf_pkg::OFS_TMR1_HI: tmr1_hi_r <= REG_WDATA;
                bbf_pkg::OFS_TMR2_LO: tmr2_lo_r <= REG_WDATA;
                bbf_pkg::OFS_TMR2_HI: tmr2_hi_r <= REG_WDATA;
                // Reserved upper bits always read zero.
                bbf_pkg::OFS_CTRL:    ctrl_r    <= REG_WDATA & bbf_pkg::CTRL_MASK;
                default: ;
            endcase
        end
    end

    logic [4:0] sel;
    logic       feat_en;

    assign sel     = ctrl_r[bbf_pkg::CTRL_SEL_MSB:bbf_pkg::CTRL_SEL_LSB];
    assign feat_en = ctrl_r[bbf_pkg::CTRL_EN_BIT];

    // ------------------------------------------------------------------
    // Failure pin selection
    // ------------------------------------------------------------------
    logic [16:0] gpio_s;

    bbf_sync #(
        .W(bbf_pkg::NUM_PINS)
    ) u_sync (
        .clk   (MCLK),
        .rst_n (rst_n_r),
        .ce    (CE),
        .d     (GPIO_IN),
        .q     (gpio_s)
    );

    // Codes index the pin bank directly; reserved and unlisted codes read
    // as no failure so a bad setting can never fire the sequence.
    function automatic logic pick_pin(input logic [4:0] code, input logic [16:0] pins);
        if (code == bbf_pkg::SEL_RESERVED || code > 5'(bbf_pkg::NUM_PINS - 1)) begin
            pick_pin = 1'b1;
        end else begin
            pick_pin = pins[code];
        end
    endfunction

    logic fail_n;

    assign fail_n = pick_pin(sel, gpio_s);

    logic fail_req;

    // feature gate; active low failure input
    assign fail_req = feat_en && !fail_n;

    // ------------------------------------------------------------------
    // Tick and timers
    // ------------------------------------------------------------------
    localparam int TW = $clog2(bbf_pkg::TICK_CYC);
    logic [TW-1:0] pre_r;
    logic          tick;

    // The prescaler runs free from reset, so a timer started mid-period sees
    // its first tick early; expiry can land up to one tick short of the limit.
    assign tick = (pre_r == TW'(bbf_pkg::TICK_CYC - 1));

    always_ff @(posedge MCLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            pre_r <= '0;
        end else if (CE) begin
            pre_r <= tick ? '0 : pre_r + TW'(1);
        end
    end

    bbf_pkg::bbf_state_e state_r;
    logic                in_bill;
    logic                exp1;
    logic                exp2;
    logic                run1;
    logic                run2;

    assign in_bill = (state_r == bbf_pkg::ST_BILL);

    // Both timers are held clear outside billboard mode, so a stale count can
    // never cut short the next failure sequence.
    // address starts first timer
    bbf_timer u_tmr1 (
        .clk     (MCLK),
        .rst_n   (rst_n_r),
        .ce      (CE),
        .start   (in_bill && ADDR_SET),
        .stop    (!in_bill),
        .tick    (tick),
        .limit   ({tmr1_hi_r, tmr1_lo_r}),
        .expired (exp1),
        .running (run1)
    );

    bbf_timer u_tmr2 (
        .clk     (MCLK),
        .rst_n   (rst_n_r),
        .ce      (CE),
        .start   (in_bill && ALT_STR_REQ),
        .stop    (!in_bill),
        .tick    (tick),
        .limit   ({tmr2_hi_r, tmr2_lo_r}),
        .expired (exp2),
        .running (run2)
    );

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    localparam int DW = $clog2(bbf_pkg::DETACH_CYC + 1);
    logic [DW-1:0] det_r;
    logic          det_done;

    // The forced detach lasts exactly the detach count of cycles, long enough
    // for the hub port to see the function leave.
    assign det_done = (det_r == DW'(bbf_pkg::DETACH_CYC - 1));

    always_ff @(posedge MCLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            det_r <= '0;
        end else if (CE) begin
            if (state_r == bbf_pkg::ST_DET_BB || state_r == bbf_pkg::ST_DET_STD) begin
                det_r <= det_done ? '0 : det_r + DW'(1);
            end else begin
                det_r <= '0;
            end
        end
    end

    bbf_pkg::bbf_state_e state_nxt;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            bbf_pkg::ST_NORMAL: begin
                if (fail_req) begin
                    state_nxt = bbf_pkg::ST_DET_BB;
                end
            end
            bbf_pkg::ST_DET_BB: begin
                if (det_done) begin
                    state_nxt = bbf_pkg::ST_BILL;
                end
            end
            bbf_pkg::ST_BILL: begin
                if (exp1 || exp2) begin
                    state_nxt = bbf_pkg::ST_DET_STD;
                end
            end
            bbf_pkg::ST_DET_STD: begin
                if (det_done) begin
                    state_nxt = bbf_pkg::ST_HOLD;
                end
            end
            bbf_pkg::ST_HOLD: begin
                // rearm after the pin returns high or the feature is disabled
                if (fail_n || !feat_en) begin
                    state_nxt = bbf_pkg::ST_NORMAL;
                end
            end
            default: state_nxt = bbf_pkg::ST_NORMAL;
        endcase
    end

    always_ff @(posedge MCLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r <= bbf_pkg::ST_NORMAL;
        end else if (CE) begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // FUNC_CONNECT, BILLBOARD_MODE and MSG_FROM_OTP follow the next state so they change on the same edge as the
    // state register and never lag it by a cycle; ALT_STR_ACK is decoded from the current state.
    always_ff @(posedge MCLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            FUNC_CONNECT      <= 1'b1;
            BILLBOARD_MODE    <= 1'b0;
            MSG_FROM_OTP      <= 1'b0;
            ALT_STR_ACK       <= 1'b0;
            CONFIGURED_STATUS <= bbf_pkg::CFG_UNSPEC;
        end else if (CE) begin
            // detach while in a detach state; reconnect standard
            FUNC_CONNECT      <= !(state_nxt == bbf_pkg::ST_DET_BB ||
                                   state_nxt == bbf_pkg::ST_DET_STD);
            // billboard descriptors; only after a failure
            BILLBOARD_MODE    <= (state_nxt == bbf_pkg::ST_BILL);
            // message source is the one-time-programmable store
            MSG_FROM_OTP      <= (state_nxt == bbf_pkg::ST_BILL);
            ALT_STR_ACK       <= in_bill && ALT_STR_REQ;
            CONFIGURED_STATUS <= bbf_pkg::CFG_UNSPEC;
        end
    end

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    // Status word: bits 4:0 one-hot state, bit 5 selected pin low now, bit 6 first
    // timer running, bit 7 second timer running. Writes to it are ignored.
    always_ff @(posedge MCLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            REG_RDATA <= 8'h00;
        end else if (CE) begin
            REG_RDATA <= 8'h00;
            if (REG_RD) begin
                unique case (REG_ADDR)
                    bbf_pkg::OFS_TMR1_LO: REG_RDATA <= tmr1_lo_r;
                    bbf_pkg::OFS_TMR1_HI: REG_RDATA <= tmr1_hi_r;
                    bbf_pkg::OFS_TMR2_LO: REG_RDATA <= tmr2_lo_r;
                    bbf_pkg::OFS_TMR2_HI: REG_RDATA <= tmr2_hi_r;
                    bbf_pkg::OFS_CTRL:    REG_RDATA <= ctrl_r;
                    bbf_pkg::OFS_STATUS:  REG_RDATA <= {run2, run1, !fail_n, state_r};
                    default:              REG_RDATA <= 8'h00;
                endcase
            end
        end
    end

endmodule

// [bbf_properties.sv]
// Port-level assertions for the billboard failover control block.
`timescale 1ns/1ns
module bbf_props (
    input wire logic        MCLK,
    input wire logic        ARST_N,
    input wire logic        CE,
    input wire logic        ALT_STR_REQ,
    input wire logic [15:0] REG_ADDR,
    input wire logic [7:0]  REG_WDATA,
    input wire logic        REG_WR,
    input wire logic        REG_RD,
    input wire logic [7:0]  REG_RDATA,
    input wire logic        FUNC_CONNECT,
    input wire logic        BILLBOARD_MODE,
    input wire logic        MSG_FROM_OTP,
    input wire logic        ALT_STR_ACK,
    input wire logic [1:0]  CONFIGURED_STATUS
);
    // -------------
    // Helper state
    // -------------
    // The control shadow lets the feature gate be judged from the ports alone.
    localparam logic [15:0] DET_LEN = 16'(bbf_pkg::DETACH_CYC);
    logic [7:0]  ctl_r;
    logic [15:0] low_cnt_r;
    logic        rd_ctl;
    logic        idle_off;
    assign rd_ctl   = CE && REG_RD && REG_ADDR == bbf_pkg::OFS_CTRL;
    assign idle_off = !ctl_r[0] && FUNC_CONNECT && !BILLBOARD_MODE;

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!ARST_N);

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ctl_r <= bbf_pkg::CTRL_RST;
        end else if (CE && REG_WR && REG_ADDR == bbf_pkg::OFS_CTRL) begin
            ctl_r <= REG_WDATA & bbf_pkg::CTRL_MASK;
        end
    end

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            low_cnt_r <= 16'h0000;
        end else if (FUNC_CONNECT) begin
            low_cnt_r <= 16'h0000;
        end else if (CE) begin
            low_cnt_r <= low_cnt_r + 16'h0001;
        end
    end

    // -------------
    // Assertions
    // -------------
    cfg_status_zero_a: assert property (CONFIGURED_STATUS == 2'h0)
        else $error("configured status not zero");
    otp_msg_a: assert property (MSG_FROM_OTP == BILLBOARD_MODE)
        else $error("message source differs from billboard mode");
    read_idle_a: assert property ($past(CE) && !$past(REG_RD) |-> REG_RDATA == 8'h00)
        else $error("read data outside its cycle");
    ctrl_read_a: assert property (rd_ctl |=> REG_RDATA == ctl_r)
        else $error("control readback wrong");
    off_no_detach_a: assert property (idle_off |=> FUNC_CONNECT)
        else $error("detach while feature disabled");
    ack_cause_a: assert property (ALT_STR_ACK |-> $past(ALT_STR_REQ) && $past(BILLBOARD_MODE))
        else $error("string answer without request");
    detach_len_a: assert property ($rose(FUNC_CONNECT) |-> low_cnt_r == DET_LEN)
        else $error("detach length wrong");
    bill_enter_a: assert property ($rose(BILLBOARD_MODE) |-> $rose(FUNC_CONNECT))
        else $error("billboard mode without reattach");
    std_exit_a: assert property ($fell(BILLBOARD_MODE) |-> $fell(FUNC_CONNECT))
        else $error("billboard exit without detach");

    cover property ($rose(BILLBOARD_MODE));
    cover property (ALT_STR_ACK);
    cover property (rd_ctl);
endmodule

bind bbf_ctrl bbf_props bbf_props_i (.MCLK, .ARST_N, .CE, .ALT_STR_REQ, .REG_ADDR,
    .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .FUNC_CONNECT, .BILLBOARD_MODE,
    .MSG_FROM_OTP, .ALT_STR_ACK, .CONFIGURED_STATUS);

// [bbf_peer.sv]
// Far-side model: fault line of the power delivery controller and host events.
`timescale 1ns/1ns
module bbf_peer (
    input  wire logic        clk,
    input  wire logic [4:0]  sel,
    input  wire logic        fail,
    input  wire logic        addr_go,
    input  wire logic        alt_go,
    output logic      [16:0] gpio = 17'h1ffff,
    output logic             addr_set = 1'b0,
    output logic             alt_req = 1'b0
);
    logic [16:0] mix;

    // Unselected pins wander every cycle, so a wrong pin pick shows up.
    always @(posedge clk) begin
        mix = 17'($urandom);
        if (sel <= 5'h10) begin
            mix[sel] = !fail;
        end
        gpio     <= mix;
        addr_set <= addr_go;
        alt_req  <= alt_go;
    end
endmodule

// [tb.sv]
// Self-checking bench for the billboard failover control block.
`timescale 1ns/1ns
module tb;
    logic        MCLK = 1'b0;
    logic        ARST_N = 1'b0;
    logic [16:0] GPIO_IN;
    logic        ADDR_SET, ALT_STR_REQ, FUNC_CONNECT, BILLBOARD_MODE, MSG_FROM_OTP;
    logic        ALT_STR_ACK;
    logic [15:0] REG_ADDR = 16'h0000;
    logic [7:0]  REG_WDATA = 8'h00;
    logic        REG_WR = 1'b0;
    logic        REG_RD = 1'b0;
    logic [7:0]  REG_RDATA;
    logic [1:0]  CONFIGURED_STATUS;
    logic [4:0]  sel = 5'h0a;
    logic        fail = 1'b0;
    logic        addr_go = 1'b0;
    logic        alt_go = 1'b0;
    logic [7:0]  d;
    logic [7:0]  wv;
    logic        CE = 1'b1;
    int          mismatches = 0;
    int          checks_done = 0;
    int          cycles = 0;

    always #10 MCLK = ~MCLK;
    bbf_ctrl bbf_ctrl_i (.MCLK, .ARST_N, .CE, .GPIO_IN, .ADDR_SET, .ALT_STR_REQ,
        .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .FUNC_CONNECT,
        .BILLBOARD_MODE, .MSG_FROM_OTP, .ALT_STR_ACK, .CONFIGURED_STATUS);
    bbf_peer bbf_peer_i (.clk(MCLK), .sel, .fail, .addr_go, .alt_go, .gpio(GPIO_IN),
        .addr_set(ADDR_SET), .alt_req(ALT_STR_REQ));

    // -------------
    // Shared tasks
    // -------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [7:0] exp_reg(input int i, input logic [7:0] v);
        return (i == 4) ? (v & bbf_pkg::CTRL_MASK) : v;
    endfunction
    task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] wd,
                       output logic [7:0] rv);
        @(posedge MCLK);
        REG_ADDR <= a;
        REG_WDATA <= wd;
        REG_WR <= w;
        REG_RD <= !w;
        @(posedge MCLK);
        REG_WR <= 1'b0;
        REG_RD <= 1'b0;
        #1 rv = REG_RDATA;
    endtask
    task automatic rchk(input logic [15:0] a, input logic [7:0] e);
        acc(1'b0, a, 8'h00, d);
        chk(16'(d), 16'(e));
    endtask
    task automatic do_reset;
        ARST_N <= 1'b0;
        fail <= 1'b0;
        repeat (12) @(posedge MCLK);
        ARST_N <= 1'b1;
        repeat (3) @(posedge MCLK);
    endtask
    task automatic host(input logic a, input logic s);
        addr_go <= a;
        alt_go <= s;
        @(posedge MCLK);
        addr_go <= 1'b0;
        alt_go <= 1'b0;
    endtask
    task automatic wait_for(input logic ack, input logic v, input int lim, output int n);
        n = 0;
        while ((ack ? ALT_STR_ACK : FUNC_CONNECT) !== v && n < lim) begin
            @(posedge MCLK);
            #1 n++;
        end
    endtask
    // Each sequence needs a reset, as the default timeout is far beyond the run.
    task automatic run_seq(input logic [4:0] c);
        int n;
        // The peer must drive the new pin high before the synchroniser leaves reset.
        sel <= c;
        do_reset();
        acc(1'b1, bbf_pkg::OFS_CTRL, {2'b00, c, 1'b1}, d);
        host(1'b1, 1'b1);
        repeat (3) @(posedge MCLK);
        rchk(bbf_pkg::OFS_STATUS, 8'h01);
        fail <= 1'b1;
        wait_for(1'b0, 1'b0, 20, n);
        wait_for(1'b0, 1'b1, 6000, n);
        chk(16'(n), 16'(bbf_pkg::DETACH_CYC));
        chk(16'(BILLBOARD_MODE), 16'h0001);
        chk(16'(MSG_FROM_OTP), 16'h0001);
        chk(16'(CONFIGURED_STATUS), 16'h0000);
        host(1'b0, 1'b1);
        wait_for(1'b1, 1'b1, 4, n);
        chk(16'(n), 16'h0001);
        @(posedge MCLK);
        #1 chk(16'(ALT_STR_ACK), 16'h0000);
        host(1'b1, 1'b0);
        repeat (3) @(posedge MCLK);
        acc(1'b0, bbf_pkg::OFS_STATUS, 8'h00, d);
        chk(16'({d[7:6], d[4:0]}), 16'h0064);
        // A pin that bounces high and low again must not start a second detach.
        fail <= 1'b0;
        repeat (10) @(posedge MCLK);
        fail <= 1'b1;
        repeat (100) @(posedge MCLK);
        #1 chk(16'(FUNC_CONNECT), 16'h0001);
        chk(16'(BILLBOARD_MODE), 16'h0001);
    endtask
    task automatic tally_and_finish;
        if (mismatches == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    always @(posedge MCLK) begin
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    // -------------
    // Main sequence
    // -------------
    initial begin
        void'($urandom(12));
        do_reset();
        rchk(bbf_pkg::OFS_TMR1_LO, 8'hd0);
        rchk(bbf_pkg::OFS_TMR1_HI, 8'h07);
        rchk(bbf_pkg::OFS_TMR2_LO, 8'hd0);
        rchk(bbf_pkg::OFS_TMR2_HI, 8'h07);
        rchk(bbf_pkg::OFS_CTRL, 8'h14);
        // A write while the clock enable is low must leave the register alone.
        @(posedge MCLK);
        CE <= 1'b0;
        acc(1'b1, bbf_pkg::OFS_TMR1_LO, 8'h5a, d);
        @(posedge MCLK);
        CE <= 1'b1;
        rchk(bbf_pkg::OFS_TMR1_LO, 8'hd0);
        for (int i = 0; i < 5; i++) begin
            wv = 8'($urandom);
            acc(1'b1, bbf_pkg::OFS_TMR1_LO + 16'(i), wv, d);
            rchk(bbf_pkg::OFS_TMR1_LO + 16'(i), exp_reg(i, wv));
        end
        acc(1'b1, 16'h4142, 8'hff, d);
        rchk(16'h4142, 8'h00);
        do_reset();
        sel <= 5'h09;
        fail <= 1'b1;
        acc(1'b1, bbf_pkg::OFS_CTRL, 8'h13, d);
        repeat (30) @(posedge MCLK);
        #1 chk(16'(FUNC_CONNECT), 16'h0001);
        sel <= 5'h0a;
        acc(1'b1, bbf_pkg::OFS_CTRL, 8'h14, d);
        repeat (30) @(posedge MCLK);
        #1 chk(16'(FUNC_CONNECT), 16'h0001);
        run_seq(5'h0a);
        run_seq(5'h00);
        run_seq(5'h10);
        run_seq(5'($urandom_range(15, 10)));
        tally_and_finish();
    end
endmodule
